// *** conv_model.sv ***
// Behavioural model of the two analog converters behind the scan controller
`timescale 1ns/1ps
`default_nettype none
module conv_model #(
  parameter int DLY0 = 2,
  parameter int DLY1 = 7
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire sar_adc_scan_pkg::conv_req_s [1:0] conv_req,
  output sar_adc_scan_pkg::conv_rsp_s [1:0] conv_rsp
);
  import sar_adc_scan_pkg::*;
  // First converter answers promptly, second one slowly
  for (genvar k = 0; k < 2; k++) begin : g_conv
    logic [7:0] cnt_r;
    logic [11:0] val_r;
    logic [11:0] raw;
    assign raw = {4'hA ^ 4'(k), conv_req[k].channel_select, conv_req[k].channel_select};
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        cnt_r <= 8'h00;
        val_r <= 12'h000;
      end else if (conv_req[k].start) begin
        cnt_r <= (k == 0) ? 8'(DLY0) : 8'(DLY1);
        val_r <= raw & (12'hFFF >> (2'h3 - conv_req[k].width));
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
    assign conv_rsp[k].done = (cnt_r == 8'h01);
    // Value is only held while done stands; elsewhere it is scrambled
    assign conv_rsp[k].value = conv_rsp[k].done ? val_r : ~val_r;
  end
endmodule : conv_model
`default_nettype wire

// *** sar_adc_scan_controller.sv ***
// Scan controllers and low-power single-conversion controllers for two converters
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_scan_controller (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sar_adc_scan_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic deep_sleep,
  input wire logic [1:0] cop_start,
  output sar_adc_scan_pkg::conv_req_s [1:0] conv_req,
  input wire sar_adc_scan_pkg::conv_rsp_s [1:0] conv_rsp,
  output logic hall_sense_en,
  input wire logic audio_ws,
  output logic audio_result_ready,
  output logic [15:0] dma_data,
  output logic dma_valid,
  input wire logic dma_ready,
  output logic scan_done_irq
);
  import sar_adc_scan_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_CONV, S_WAIT, S_PACK, S_EMIT} scan_state_e;

  logic [1:0] mode_r;
  logic single_sel_r;
  logic route_r;
  logic [1:0] owner_r;
  logic [3:0] last_r;
  logic hall_r;
  logic [3:0] lp_chan_r [2];
  logic [1:0] lp_atten_r [2];
  logic [1:0] lp_res_r [2];
  logic [1:0] lp_busy_r;
  logic [1:0] lp_done_r;
  logic [11:0] lp_result_r [2];
  logic [7:0] tab_r [2][TAB_ITEMS];
  logic [31:0] rdata_r;
  logic err_r;
  logic ws_s1_r;
  logic ws_s2_r;
  logic ws_s3_r;

  scan_state_e state_r;
  scan_state_e state_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic turn_r;
  logic turn_nxt;
  logic emit_r;
  logic emit_nxt;
  logic fin_nxt;
  logic [1:0] need_r;
  logic [1:0] need_w;
  logic [1:0] got_r;
  logic [3:0] ch_r [2];
  logic [1:0] w_r [2];
  logic [11:0] res_r [2];

  // Bus decode
  wire setup_w = psel & ~penable;
  wire access_w = psel & penable;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_lp1 = paddr == OFS_LP1_CMD;
  wire hit_lp2 = paddr == OFS_LP2_CMD;
  wire hit_res1 = paddr == OFS_LP1_RES;
  wire hit_res2 = paddr == OFS_LP2_RES;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_tab = (paddr & TAB_DECODE_MASK) == OFS_TAB_BASE;
  wire tab_sel = paddr[4];
  wire [1:0] tab_word = paddr[3:2];
  wire hit_any = hit_ctrl | hit_lp1 | hit_lp2 | hit_res1 | hit_res2 | hit_stat | hit_tab;
  wire wr_en = access_w & pwrite & ~err_r;
  wire [1:0] hit_cmd = {hit_lp2, hit_lp1};

  // Zero-wait slave; read data is sampled in the setup cycle
  assign pready = access_w;
  assign prdata = rdata_r;
  assign pslverr = access_w & err_r;

  wire scan_busy = state_r != S_IDLE;
  wire [31:0] ctrl_rd = {20'h00000, last_r, 2'h0, owner_r, route_r, single_sel_r, mode_r};
  wire [31:0] lp1_rd = {19'h0, hall_r, lp_res_r[0], lp_atten_r[0], lp_chan_r[0], 4'h0};
  wire [31:0] lp2_rd = {19'h0, 1'b0, lp_res_r[1], lp_atten_r[1], lp_chan_r[1], 4'h0};
  wire [31:0] res1_rd = {lp_done_r[0], lp_busy_r[0], 18'h0, lp_result_r[0]};
  wire [31:0] res2_rd = {lp_done_r[1], lp_busy_r[1], 18'h0, lp_result_r[1]};
  wire [31:0] stat_rd = {27'h0, idx_r, scan_busy};
  wire [31:0] tab_rd = {tab_r[tab_sel][{tab_word, 2'h3}], tab_r[tab_sel][{tab_word, 2'h2}],
                        tab_r[tab_sel][{tab_word, 2'h1}], tab_r[tab_sel][{tab_word, 2'h0}]};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_lp1 ? lp1_rd :
                       hit_lp2 ? lp2_rd :
                       hit_res1 ? res1_rd :
                       hit_res2 ? res2_rd :
                       hit_stat ? stat_rd :
                       hit_tab ? tab_rd : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else if (setup_w) begin
      rdata_r <= pwrite ? 32'h00000000 : rd_mux;
      err_r <= ~hit_any;
    end
  end

  // Control register; the scan-go bit is a write pulse and reads as zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_r <= MODE_SINGLE;
      single_sel_r <= 1'b0;
      route_r <= 1'b0;
      owner_r <= 2'h0;
      last_r <= RST_LAST_INDEX;
    end else if (wr_en & hit_ctrl) begin
      mode_r <= pwdata[CTRL_MODE_LSB +: 2];
      single_sel_r <= pwdata[CTRL_SINGLE_SEL];
      route_r <= pwdata[CTRL_ROUTE];
      owner_r <= pwdata[CTRL_OWNER_LSB +: 2];
      last_r <= pwdata[CTRL_LAST_LSB +: 4];
    end
  end

  // Pattern tables, byte lanes honoured so one item can be patched alone
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int t = 0; t < 2; t++) begin
        for (int i = 0; i < TAB_ITEMS; i++) begin
          tab_r[t][i] <= RST_ITEM;
        end
      end
    end else if (wr_en & hit_tab) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          tab_r[tab_sel][{tab_word, 2'(b)}] <= pwdata[8*b +: 8];
        end
      end
    end
  end

  // Low-power controllers: one conversion per start, no sequencing
  conv_req_s [1:0] lp_req;
  conv_req_s [1:0] scan_req;
  conv_req_s [1:0] conv_req_nxt;
  rule_item_s item_w [2];
  logic [1:0] lp_go;
  logic [1:0] lp_fin;
  logic [1:0] sw_go;

  for (genvar k = 0; k < 2; k++) begin : g_lp
    assign sw_go[k] = wr_en & hit_cmd[k] & pwdata[LP_START];
    assign lp_go[k] = (deep_sleep ? cop_start[k] : (cop_start[k] | sw_go[k]))
                      & ~lp_busy_r[k] & ~owner_r[k];
    assign lp_fin[k] = lp_busy_r[k] & ~owner_r[k] & conv_rsp[k].done;
    assign lp_req[k] = '{start: lp_go[k],
                         channel_select: sw_go[k] ? pwdata[LP_CHAN_LSB +: 4] : lp_chan_r[k],
                         width: sw_go[k] ? pwdata[LP_RES_LSB +: 2] : lp_res_r[k],
                         atten: sw_go[k] ? pwdata[LP_ATTEN_LSB +: 2] : lp_atten_r[k]};
    assign item_w[k] = rule_item_s'(tab_r[k][idx_r]);
    assign scan_req[k] = '{start: (state_r == S_CONV) & need_w[k],
                           channel_select: item_w[k].channel_select,
                           width: item_w[k].width, atten: item_w[k].atten};
    assign conv_req_nxt[k] = owner_r[k] ? scan_req[k] : lp_req[k];
  end

  // The first low-power controller drives the first converter while owner bit 0 is clear
  assign hall_sense_en = hall_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hall_r <= 1'b0;
      lp_busy_r <= 2'h0;
      lp_done_r <= 2'h0;
      conv_req <= '0;
      for (int k = 0; k < 2; k++) begin
        lp_chan_r[k] <= 4'h0;
        lp_atten_r[k] <= 2'h0;
        lp_res_r[k] <= RST_RES;
        lp_result_r[k] <= 12'h000;
      end
    end else begin
      conv_req <= conv_req_nxt;
      lp_busy_r <= lp_go | (lp_busy_r & ~lp_fin);
      lp_done_r <= lp_fin | (lp_done_r & ~lp_go);
      if (wr_en & hit_lp1) begin
        hall_r <= pwdata[LP_HALL];
      end
      for (int k = 0; k < 2; k++) begin
        if (wr_en & hit_cmd[k]) begin
          lp_chan_r[k] <= pwdata[LP_CHAN_LSB +: 4];
          lp_atten_r[k] <= pwdata[LP_ATTEN_LSB +: 2];
          lp_res_r[k] <= pwdata[LP_RES_LSB +: 2];
        end
        if (lp_fin[k]) begin
          lp_result_r[k] <= conv_rsp[k].value;
        end
      end
    end
  end

  // Word-select pin synchroniser; the third stage only feeds the edge detector
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ws_s1_r <= 1'b0;
      ws_s2_r <= 1'b0;
      ws_s3_r <= 1'b0;
    end else begin
      ws_s1_r <= audio_ws;
      ws_s2_r <= ws_s1_r;
      ws_s3_r <= ws_s2_r;
    end
  end
  wire ws_edge = ws_s2_r ^ ws_s3_r;

  // Scan sequencing
  wire is_single = (mode_r != MODE_DOUBLE) && (mode_r != MODE_ALT);
  wire alt_w = mode_r == MODE_ALT;
  assign need_w = (mode_r == MODE_DOUBLE) ? 2'b11 :
                      alt_w ? (turn_r ? 2'b10 : 2'b01) :
                      (single_sel_r ? 2'b10 : 2'b01);
  wire owned_w = (need_w & ~owner_r) == 2'b00;
  wire sw_scan = wr_en & hit_ctrl & pwdata[CTRL_SCAN_GO];
  // Software and audio triggers never mix: the routing bit picks one source
  wire trig_w = route_r ? ws_edge : sw_scan;
  wire [1:0] done_w = {conv_rsp[1].done & owner_r[1], conv_rsp[0].done & owner_r[0]};
  wire [1:0] got_w = got_r | (need_r & done_w);
  wire last_w = idx_r == last_r;
  wire pair_w = need_r == 2'b11;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    turn_nxt = turn_r;
    emit_nxt = emit_r;
    fin_nxt = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (trig_w && owned_w) begin
          state_nxt = S_CONV;
        end
      end
      S_CONV: state_nxt = S_WAIT;
      S_WAIT: begin
        if (got_w == need_r) begin
          state_nxt = S_PACK;
          emit_nxt = ~need_r[0];
        end
      end
      S_PACK: state_nxt = S_EMIT;
      S_EMIT: begin
        if (dma_ready) begin
          if (pair_w && !emit_r) begin
            emit_nxt = 1'b1;
            state_nxt = S_PACK;
          end else if (alt_w && !turn_r) begin
            turn_nxt = 1'b1;
            state_nxt = route_r ? S_IDLE : S_CONV;
          end else begin
            turn_nxt = 1'b0;
            idx_nxt = last_w ? 4'h0 : idx_r + 4'h1;
            fin_nxt = last_w;
            state_nxt = (route_r || last_w) ? S_IDLE : S_CONV;
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Packing: values arrive right-aligned at the selected width
  wire [3:0] pk_ch = ch_r[emit_r];
  wire [11:0] pk_val = res_r[emit_r];
  wire [10:0] pk_val11 = (w_r[emit_r] == WIDTH_12) ? pk_val[11:1] : pk_val[10:0];
  wire [15:0] pack_w = is_single ? {pk_ch, pk_val} :
                       {emit_r, pk_ch, pk_val11};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      idx_r <= 4'h0;
      turn_r <= 1'b0;
      emit_r <= 1'b0;
      need_r <= 2'h0;
      got_r <= 2'h0;
      scan_done_irq <= 1'b0;
      dma_data <= 16'h0000;
      for (int k = 0; k < 2; k++) begin
        ch_r[k] <= 4'h0;
        w_r[k] <= 2'h0;
        res_r[k] <= 12'h000;
      end
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      turn_r <= turn_nxt;
      emit_r <= emit_nxt;
      scan_done_irq <= fin_nxt;
      got_r <= (state_r == S_CONV) ? 2'h0 : got_w;
      if (state_r == S_CONV) begin
        need_r <= need_w;
      end
      if (state_r == S_PACK) begin
        dma_data <= pack_w;
      end
      for (int k = 0; k < 2; k++) begin
        if (state_r == S_CONV) begin
          ch_r[k] <= item_w[k].channel_select;
          w_r[k] <= item_w[k].width;
        end
        if (state_r == S_WAIT && need_r[k] && done_w[k]) begin
          res_r[k] <= conv_rsp[k].value;
        end
      end
    end
  end

  assign dma_valid = state_r == S_EMIT;
  // Results never reach the audio side unless routing is on
  assign audio_result_ready = dma_valid & route_r;

  // Checks
  wire [11:0] rsp0_val = conv_rsp[0].value;
  wire [3:0] item0_ch = item_w[0].channel_select;
  wire emit_st = state_r == S_EMIT;
  wire lp1_sw = wr_en & hit_lp1 & pwdata[LP_START];

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_lp_sw_start: assert property (
    lp1_sw && !deep_sleep && !lp_busy_r[0] && !owner_r[0] |=> conv_req[0].start)
    else $error("low-power start not issued");
  a_lp_result_load: assert property (
    lp_busy_r[0] && !owner_r[0] && conv_rsp[0].done
    |=> lp_done_r[0] && lp_result_r[0] == $past(rsp0_val))
    else $error("low-power result not captured");
  a_lp_one_shot: assert property (
    lp_busy_r[0] && !owner_r[0] && !conv_rsp[0].done |=> !conv_req[0].start)
    else $error("second start while busy");
  a_sleep_cop_only: assert property (
    deep_sleep && !cop_start[0] && !owner_r[0] |=> !conv_req[0].start)
    else $error("start in deep sleep without coprocessor");
  a_scan_fetch: assert property (
    state_r == S_CONV && need_w[0] && owner_r[0]
    |=> conv_req[0].start && conv_req[0].channel_select == $past(item0_ch))
    else $error("scan entry not applied");
  a_idx_wrap: assert property (
    emit_st && dma_ready && last_w && !pair_w && !(alt_w && !turn_r) |=> idx_r == 4'h0)
    else $error("index did not wrap");
  a_done_pulse: assert property (
    scan_done_irq |-> $past(emit_st) && $past(last_w) ##1 !scan_done_irq)
    else $error("scan done pulse wrong");
  a_double_both: assert property (
    state_r == S_CONV && mode_r == MODE_DOUBLE && owner_r == 2'b11
    |=> conv_req[0].start && conv_req[1].start)
    else $error("double mode start missing");
  a_alt_turn: assert property (
    state_r == S_CONV && alt_w && owner_r == 2'b11
    |=> conv_req[1].start == $past(turn_r) && conv_req[0].start != $past(turn_r))
    else $error("alternate turn wrong");
  a_single_fmt: assert property (
    dma_valid && is_single |-> dma_data[15:12] == ch_r[emit_r])
    else $error("single word channel wrong");
  a_pair_fmt: assert property (
    dma_valid && !is_single |-> dma_data[15] == emit_r && dma_data[14:11] == ch_r[emit_r])
    else $error("second format header wrong");
  a_ws_trigger: assert property (
    state_r == S_IDLE && route_r && ws_edge && owned_w |=> state_r == S_CONV ##1 state_r == S_WAIT)
    else $error("word select did not trigger");

  c_double_pair: cover property (emit_st && dma_ready && pair_w && !emit_r);
  c_audio_done: cover property (scan_done_irq && route_r);
  c_sleep_conv: cover property (lp_fin[0] && deep_sleep);
endmodule : sar_adc_scan_controller
`default_nettype wire

// *** sar_adc_scan_pkg.sv ***
// Shared constants and types of the two-converter scan controller
//
// Contract
// - Writing a low-power start request begins one conversion
// - A finished low-power conversion is readable in its result register
// - Low-power controllers do single conversions only, no scanning or DMA
// - In deep sleep only the coprocessor may start low-power conversions
// - Each scan controller owns a sixteen-entry pattern table
// - A scan fetches entries in order, one per measurement
// - The scan sequence holds at most sixteen entries, then wraps
// - Entry bits: channel [7:4], resolution [3:2], attenuation [1:0]
// - Single mode scans one converter only, first or second
// - Double mode scans both converters together, each from its own table
// - Alternate mode takes turns between first and second converter
// - A scan starts on a software request or an audio trigger
// - A finished scan raises an interrupt
// - DMA words are 16 bits; single mode adds the channel number
// - Double and alternate words add channel and converter bit
// - First format: channel in [15:12], 12-bit value below
// - Second format: converter bit, channel, 11-bit value
// - Values are limited to twelve or eleven bits by format
// - Each audio word-select transition triggers one measurement
// - The audio data line signals a result ready for transfer
// - Audio connection exists only while the routing bit is set
// - Magnetic readings use the first converter and low-power controller
// - Resolution code 0..3 selects nine to twelve bits
// - Owner bit hands the first converter to scan when set
package sar_adc_scan_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LP1_CMD = 8'h04;
  localparam logic [7:0] OFS_LP2_CMD = 8'h08;
  localparam logic [7:0] OFS_LP1_RES = 8'h0C;
  localparam logic [7:0] OFS_LP2_RES = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TAB_BASE = 8'h20;
  localparam logic [7:0] TAB_DECODE_MASK = 8'hE3;
  localparam int TAB_ITEMS = 16;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SINGLE_SEL = 2;
  localparam int CTRL_ROUTE = 3;
  localparam int CTRL_OWNER_LSB = 4;
  localparam int CTRL_LAST_LSB = 8;
  localparam int CTRL_SCAN_GO = 16;
  localparam int LP_START = 0;
  localparam int LP_CHAN_LSB = 4;
  localparam int LP_ATTEN_LSB = 8;
  localparam int LP_RES_LSB = 10;
  localparam int LP_HALL = 12;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] WIDTH_12 = 2'h3;
  localparam logic [3:0] RST_LAST_INDEX = 4'hF;
  localparam logic [7:0] RST_ITEM = 8'h00;
  localparam logic [1:0] RST_RES = 2'h3;
  typedef struct packed {
    logic [3:0] channel_select;
    logic [1:0] width;
    logic [1:0] atten;
  } rule_item_s;
  typedef struct packed {
    logic start;
    logic [3:0] channel_select;
    logic [1:0] width;
    logic [1:0] atten;
  } conv_req_s;
  typedef struct packed {
    logic done;
    logic [11:0] value;
  } conv_rsp_s;
endpackage : sar_adc_scan_pkg

// *** testbench.sv ***
// Self-checking bench for the two-converter scan controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sar_adc_scan_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic deep_sleep = 1'b0;
  logic [1:0] cop_start = 2'h0;
  conv_req_s [1:0] conv_req;
  conv_rsp_s [1:0] conv_rsp;
  logic hall_sense_en;
  logic audio_ws = 1'b0;
  logic audio_result_ready;
  logic [15:0] dma_data;
  logic dma_valid;
  logic dma_ready = 1'b0;
  logic scan_done_irq;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] tab [2][2] = '{'{8'h31, 8'h9C}, '{8'h2C, 8'h61}};
  always #4 ref_clk = ~ref_clk;
  sar_adc_scan_controller u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .deep_sleep(deep_sleep),
    .cop_start(cop_start), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .hall_sense_en(hall_sense_en), .audio_ws(audio_ws), .audio_result_ready(audio_result_ready),
    .dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready),
    .scan_done_irq(scan_done_irq));
  conv_model u_conv (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_req(conv_req),
    .conv_rsp(conv_rsp));
  function automatic logic [11:0] cv(input int k, input logic [3:0] ch, input logic [1:0] w);
    logic [11:0] raw;
    raw = {4'hA ^ k[3:0], ch, ch};
    return raw & (12'hFFF >> (2'h3 - w));
  endfunction : cv
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic timeout(input string what);
    error_cnt++;
    $display("mismatch at %0t: timeout in %s", $time, what);
    results();
  endtask : timeout
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout("apb");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic lp_wait(input logic [7:0] a);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[31] !== 1'b1 && n < 30);
    if (rd[31] !== 1'b1) timeout("conversion");
  endtask : lp_wait
  // Consumer stalls two cycles before taking each word
  task automatic take_word(input logic [15:0] exp, input logic route);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (dma_valid !== 1'b1 && n < 200);
    if (dma_valid !== 1'b1) timeout("dma");
    check({31'h0, audio_result_ready}, {31'h0, route}, "audio ready");
    repeat (2) @(posedge ref_clk);
    dma_ready <= 1'b1;
    @(posedge ref_clk);
    check({16'h0, dma_data}, {16'h0, exp}, "dma word");
    dma_ready <= 1'b0;
  endtask : take_word
  task automatic wait_irq();
    int n;
    logic seen;
    seen = 1'b0;
    // The pulse may already stand right after the last accepted word
    for (n = 0; n < 6; n++) begin
      #1;
      seen = seen | (scan_done_irq === 1'b1);
      @(posedge ref_clk);
    end
    check({31'h0, seen}, 32'h1, "scan irq");
  endtask : wait_irq
  task automatic t_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h00000F00, "ctrl reset");
    apb(1'b0, OFS_LP1_CMD, 32'h0);
    check(rd, 32'h00000C00, "lp cmd reset");
    apb(1'b0, 8'hFC, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped error");
  endtask : t_reset
  task automatic t_lp();
    apb(1'b1, OFS_LP1_CMD, 32'h00001851);
    @(posedge ref_clk);
    check({31'h0, hall_sense_en}, 32'h1, "hall enable");
    lp_wait(OFS_LP1_RES);
    check({20'h0, rd[11:0]}, {20'h0, cv(0, 4'h5, 2'h2)}, "lp1 value");
  endtask : t_lp
  task automatic t_sleep();
    deep_sleep <= 1'b1;
    apb(1'b1, OFS_LP2_CMD, 32'h00000C71);
    repeat (12) @(posedge ref_clk);
    apb(1'b0, OFS_LP2_RES, 32'h0);
    check({30'h0, rd[31:30]}, 32'h0, "sleep sw start refused");
    @(posedge ref_clk);
    cop_start <= 2'b10;
    @(posedge ref_clk);
    cop_start <= 2'b00;
    lp_wait(OFS_LP2_RES);
    check({20'h0, rd[11:0]}, {20'h0, cv(1, 4'h7, 2'h3)}, "lp2 value");
    deep_sleep <= 1'b0;
  endtask : t_sleep
  task automatic t_single();
    logic [7:0] it [3];
    it = '{8'h31, 8'h9C, 8'hE6};
    apb(1'b1, OFS_TAB_BASE, 32'h00E69C31);
    // Owner and mode must be in place before the start is seen
    apb(1'b1, OFS_CTRL, 32'h00000210);
    apb(1'b1, OFS_CTRL, 32'h00010210);
    for (int i = 0; i < 3; i++) begin
      take_word({it[i][7:4], cv(0, it[i][7:4], it[i][3:2])}, 1'b0);
    end
    wait_irq();
    // Owner bit now hands the first converter to the scan side
    apb(1'b1, OFS_LP1_CMD, 32'h00000C51);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFS_LP1_RES, 32'h0);
    check({rd[31:30], 18'h0, rd[11:0]}, {2'b10, 18'h0, cv(0, 4'h5, 2'h2)}, "lp owned");
  endtask : t_single
  task automatic t_multi(input logic [1:0] mode);
    logic [7:0] e;
    logic [11:0] v;
    apb(1'b1, OFS_TAB_BASE + 8'h10, 32'h0000612C);
    apb(1'b1, OFS_CTRL, 32'h00000130 | {30'h0, mode});
    apb(1'b1, OFS_CTRL, 32'h00010130 | {30'h0, mode});
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 2; k++) begin
        e = tab[k][i];
        v = cv(k, e[7:4], e[3:2]);
        take_word({k[0], e[7:4], (e[3:2] == 2'h3) ? v[11:1] : v[10:0]}, 1'b0);
      end
    end
    wait_irq();
  endtask : t_multi
  task automatic t_route();
    apb(1'b1, OFS_CTRL, 32'h00000018);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      audio_ws <= ~audio_ws;
      take_word({4'h3, cv(0, 4'h3, 2'h0)}, 1'b1);
    end
    apb(1'b1, OFS_CTRL, 32'h00000000);
  endtask : t_route
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_lp();
    t_sleep();
    t_single();
    t_multi(MODE_DOUBLE);
    t_multi(MODE_ALT);
    t_route();
    results();
  end
endmodule : testbench
`default_nettype wire
